// >>> design/hwt_downcounter.sv
// module: 16-bit down-counter core with done pulse
module hwt_downcounter
  import hwt_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              load,
  input  wire logic [DATA_W-1:0] load_value,
  input  wire logic              dec_tick,
  output logic [DATA_W-1:0]      count,
  output logic                   enabled,
  output logic                   done
);

  logic [DATA_W-1:0] count_reg;
  logic [DATA_W-1:0] count_next;
  logic              en_reg;
  logic              en_next;
  logic              done_reg;
  logic              done_next;

  // load wins over decrement; stop at zero
  always_comb begin
    count_next = count_reg;
    en_next    = en_reg;
    done_next  = 1'b0;
    if (load) begin
      count_next = load_value;
      en_next    = (load_value != COUNT_RST);
    end else if (dec_tick && en_reg && (count_reg != COUNT_RST)) begin
      count_next = count_reg - COUNT_ONE;
      if (count_reg == COUNT_ONE) begin
        done_next = 1'b1;
        en_next   = 1'b0;
      end
    end
  end

  // counter state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= COUNT_RST;
      en_reg    <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      en_reg    <= en_next;
      done_reg  <= done_next;
    end
  end

  assign count   = count_reg;
  assign enabled = en_reg;
  assign done    = done_reg;

endmodule

// >>> design/hwt_pkg.sv
// package: constants, request carrier and address decode for the wake timer
package hwt_pkg;

  // register data and address widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_RELOAD = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h08;

  // field positions
  localparam int unsigned CTRL_RES_BIT = 0;

  // reset values and unit count step
  localparam logic [DATA_W-1:0] RELOAD_RST = 16'h0000;
  localparam logic              CTRL_RST   = 1'b0;
  localparam logic [DATA_W-1:0] COUNT_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] COUNT_ONE  = 16'h0001;

  // low-frequency clock and resolutions
  localparam int unsigned LF_CLK_HZ     = 32768;
  localparam int unsigned FINE_RES_NS   = 30500;
  localparam int unsigned COARSE_RES_MS = 125;
  localparam int unsigned COARSE_TICKS  = LF_CLK_HZ * COARSE_RES_MS / 1000;
  localparam int unsigned PRESC_W       = $clog2(COARSE_TICKS);
  localparam logic [PRESC_W-1:0] PRESC_MAX  = PRESC_W'(COARSE_TICKS - 1);
  localparam logic [PRESC_W-1:0] PRESC_ZERO = '0;

  // register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] wdata;
  } hwt_req_s;

  // address match against one offset
  function automatic logic hwt_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] ofs);
    hwt_hit = (addr == ofs);
  endfunction

endpackage

// >>> design/hwt_prescaler.sv
// module: low-frequency tick detect and resolution prescaler
module hwt_prescaler
  import hwt_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clk_32k_in,
  input  wire logic coarse_sel,
  input  wire logic restart,
  output logic      tick_32k,
  output logic      count_tick
);

  logic               lf_prev_reg;
  logic               lf_prev_next;
  logic [PRESC_W-1:0] presc_reg;
  logic [PRESC_W-1:0] presc_next;

  // rising edge of the 32 kHz source
  assign tick_32k = clk_32k_in & ~lf_prev_reg;

  // one count per edge, or one per full prescale wrap
  assign count_tick = tick_32k & (~coarse_sel | (presc_reg == PRESC_MAX));

  // prescaler next value
  always_comb begin
    lf_prev_next = clk_32k_in;
    presc_next   = presc_reg;
    if (restart) begin
      presc_next = PRESC_ZERO;
    end else if (tick_32k) begin
      presc_next = (presc_reg == PRESC_MAX) ? PRESC_ZERO : presc_reg + PRESC_W'(1);
    end
  end

  // prescaler state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lf_prev_reg <= 1'b0;
      presc_reg   <= PRESC_ZERO;
    end else begin
      lf_prev_reg <= lf_prev_next;
      presc_reg   <= presc_next;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // coarse ticks only at prescale wrap
  property p_coarse_wrap;
    count_tick && coarse_sel |-> presc_reg == PRESC_MAX;
  endproperty
  a_coarse_wrap: assert property (p_coarse_wrap) else $error("coarse tick off wrap");

  // fine resolution counts every edge
  property p_fine_every;
    tick_32k && !coarse_sel |-> count_tick;
  endproperty
  a_fine_every: assert property (p_fine_every) else $error("fine tick missed");

endmodule

// >>> design/hwt_wake_timer.sv
// module: wake timer top with register file and update staging
// Function
// - counter is sixteen bits wide and counts down toward zero
// - two resolutions: 30.5 us and 0.125 s per count
// - non-zero reload write loads counter and starts counting from it
// - wake-up event raised when running count reaches zero
// - done event only when enabled and count decrements to zero
// - counter runs from 32 kHz source through a prescaler
// - reset returns all counter logic and registers to defaults
// - sleep-enable inputs are ignored; counter keeps running
// - clock-required only during accesses and until updates reach the core
// - counting depends only on the 32 kHz source, not main oscillator; all counter state here is clocked by core_clk
// - reload at 00h, resolution at 04h, count at 08h
// - coarse resolution allows wake delays up to about two hours
// - zero reload write disables counter; no further done event
// - resolution bit one selects coarse, zero selects fine
// - count register reads present value; writes have no effect
module hwt_wake_timer
  import hwt_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      rst_n,
  input  wire logic      clk_32k_in,
  input  wire logic      sleep_en,
  input  wire hwt_req_s  reg_req,
  output logic [DATA_W-1:0] reg_rdata,
  output logic           clk_required,
  output logic           wake_count_done_event
);

  logic [DATA_W-1:0] reload_reg;
  logic [DATA_W-1:0] reload_next;
  logic              ctrl_res_reg;
  logic              ctrl_res_next;
  logic              core_res_reg;
  logic              core_res_next;
  logic              pend_load_reg;
  logic              pend_load_next;
  logic              pend_res_reg;
  logic              pend_res_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              wr_reload;
  logic              wr_ctrl;
  logic              tick_32k;
  logic              count_tick;
  logic              core_load;
  logic [DATA_W-1:0] count;
  logic              enabled;
  logic              done;
  logic              sleep_seen;

  // sleep request has no path into the counter
  assign sleep_seen = sleep_en & 1'b0;

  // write strobes per register
  assign wr_reload = reg_req.wr & hwt_hit(reg_req.addr, OFS_RELOAD);
  assign wr_ctrl   = reg_req.wr & hwt_hit(reg_req.addr, OFS_CTRL);

  // staged reload reaches the core on a low-frequency edge
  assign core_load = pend_load_reg & tick_32k;

  // tick source and prescaler
  hwt_prescaler u_presc (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .clk_32k_in (clk_32k_in),
    .coarse_sel (core_res_reg),
    .restart    (core_load),
    .tick_32k   (tick_32k),
    .count_tick (count_tick)
  );

  // counter core; 16 bits of 0.125 s cover over two hours
  hwt_downcounter u_cnt (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .load       (core_load),
    .load_value (reload_reg),
    .dec_tick   (count_tick & ~sleep_seen),
    .count      (count),
    .enabled    (enabled),
    .done       (done)
  );

  // register file and staging next values
  always_comb begin
    reload_next    = reload_reg;
    ctrl_res_next  = ctrl_res_reg;
    core_res_next  = core_res_reg;
    rdata_next     = rdata_reg;
    if (wr_reload) begin
      reload_next = reg_req.wdata;
    end
    if (wr_ctrl) begin
      ctrl_res_next = reg_req.wdata[CTRL_RES_BIT];
    end
    // a new write in the apply cycle keeps its pending flag
    pend_load_next = wr_reload | (pend_load_reg & ~tick_32k);
    pend_res_next  = wr_ctrl | (pend_res_reg & ~tick_32k);
    if (pend_res_reg && tick_32k) begin
      core_res_next = ctrl_res_reg;
    end
    // read mux; count is read only, unmapped reads zero
    if (reg_req.rd) begin
      if (hwt_hit(reg_req.addr, OFS_RELOAD)) begin
        rdata_next = reload_reg;
      end else if (hwt_hit(reg_req.addr, OFS_CTRL)) begin
        rdata_next = {{(DATA_W-1){1'b0}}, ctrl_res_reg};
      end else if (hwt_hit(reg_req.addr, OFS_COUNT)) begin
        rdata_next = count;
      end else begin
        rdata_next = COUNT_RST;
      end
    end
  end

  // register file state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_reg    <= RELOAD_RST;
      ctrl_res_reg  <= CTRL_RST;
      core_res_reg  <= CTRL_RST;
      pend_load_reg <= 1'b0;
      pend_res_reg  <= 1'b0;
      rdata_reg     <= COUNT_RST;
    end else begin
      reload_reg    <= reload_next;
      ctrl_res_reg  <= ctrl_res_next;
      core_res_reg  <= core_res_next;
      pend_load_reg <= pend_load_next;
      pend_res_reg  <= pend_res_next;
      rdata_reg     <= rdata_next;
    end
  end

  // outputs
  assign reg_rdata             = rdata_reg;
  assign wake_count_done_event = done;
  assign clk_required = reg_req.rd | reg_req.wr | pend_load_reg | pend_res_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // non-zero staged reload lands in the core
  property p_load_nonzero;
    core_load && (reload_reg != COUNT_RST) |=> (count == $past(reload_reg)) && enabled;
  endproperty
  a_load_nonzero: assert property (p_load_nonzero) else $error("reload not loaded");

  // zero reload disables the counter
  property p_load_zero;
    core_load && (reload_reg == COUNT_RST) |=> !enabled && (count == COUNT_RST);
  endproperty
  a_load_zero: assert property (p_load_zero) else $error("zero reload not disabling");

  // one decrement per tick
  property p_decrement;
    count_tick && enabled && !core_load && (count != COUNT_RST)
      |=> count == $past(count) - COUNT_ONE;
  endproperty
  a_decrement: assert property (p_decrement) else $error("bad decrement");

  // no movement without a tick or load
  property p_still;
    !count_tick && !core_load |=> $stable(count);
  endproperty
  a_still: assert property (p_still) else $error("count moved without tick");

  // done only from an enabled one-to-zero step
  property p_done_cause;
    wake_count_done_event |-> $past(enabled) && ($past(count) == COUNT_ONE)
      && $past(count_tick) && (count == COUNT_RST) && !enabled;
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("spurious done event");

  // done is a single-cycle pulse
  property p_done_pulse;
    wake_count_done_event |=> !wake_count_done_event;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not one cycle");

  // expired counter holds zero until reload
  property p_hold_zero;
    (count == COUNT_RST) && !core_load |=> (count == COUNT_RST) && !wake_count_done_event;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("zero not held");

  // count read returns live value
  property p_count_read;
    reg_req.rd && hwt_hit(reg_req.addr, OFS_COUNT) |=> reg_rdata == $past(count);
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read wrong");

  // write to count changes nothing stored
  property p_count_ro;
    reg_req.wr && hwt_hit(reg_req.addr, OFS_COUNT) |=> $stable(reload_reg) && $stable(ctrl_res_reg);
  endproperty
  a_count_ro: assert property (p_count_ro) else $error("count write had effect");

  // reload write is staged, then applied at the next edge
  property p_stage;
    wr_reload |=> pend_load_reg && clk_required;
  endproperty
  a_stage: assert property (p_stage) else $error("reload write not staged");

  // clock request drops when idle
  property p_clkreq_idle;
    !reg_req.rd && !reg_req.wr && !pend_load_reg && !pend_res_reg |-> !clk_required;
  endproperty
  a_clkreq_idle: assert property (p_clkreq_idle) else $error("clock request while idle");

  // resolution reaches core at a tick
  property p_res_apply;
    pend_res_reg && tick_32k |=> core_res_reg == $past(ctrl_res_reg);
  endproperty
  a_res_apply: assert property (p_res_apply) else $error("resolution not applied");

  // reload write captures the whole word
  property p_reload_take;
    wr_reload |=> reload_reg == $past(reg_req.wdata);
  endproperty
  a_reload_take: assert property (p_reload_take) else $error("reload write lost");

  // control write keeps only the resolution bit
  property p_ctrl_take;
    wr_ctrl |=> ctrl_res_reg == $past(reg_req.wdata[CTRL_RES_BIT]);
  endproperty
  a_ctrl_take: assert property (p_ctrl_take) else $error("control write lost");

  // writes to other places leave stored values alone
  property p_wr_other;
    reg_req.wr && !wr_reload && !wr_ctrl |=> $stable(reload_reg) && $stable(ctrl_res_reg);
  endproperty
  a_wr_other: assert property (p_wr_other) else $error("stray write had effect");

  // reload read returns the stored word
  property p_rd_reload;
    reg_req.rd && hwt_hit(reg_req.addr, OFS_RELOAD) |=> reg_rdata == $past(reload_reg);
  endproperty
  a_rd_reload: assert property (p_rd_reload) else $error("reload read wrong");

  // control read returns the bit, upper bits zero
  property p_rd_ctrl;
    reg_req.rd && hwt_hit(reg_req.addr, OFS_CTRL)
      |=> reg_rdata == {{(DATA_W-1){1'b0}}, $past(ctrl_res_reg)};
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");

  // unmapped reads give zero
  property p_rd_unmapped;
    reg_req.rd && !hwt_hit(reg_req.addr, OFS_RELOAD) && !hwt_hit(reg_req.addr, OFS_CTRL)
      && !hwt_hit(reg_req.addr, OFS_COUNT) |=> reg_rdata == COUNT_RST;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  // read data holds between reads
  property p_rd_hold;
    !reg_req.rd |=> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

  // control write is staged like the reload
  property p_stage_ctrl;
    wr_ctrl |=> pend_res_reg && clk_required;
  endproperty
  a_stage_ctrl: assert property (p_stage_ctrl) else $error("control write not staged");

  // write in the apply cycle stays pending
  property p_collide;
    wr_reload && core_load |=> pend_load_reg;
  endproperty
  a_collide: assert property (p_collide) else $error("colliding write dropped");

  // pending reload flag clears once the update is applied
  property p_pend_clear;
    pend_load_reg && tick_32k && !wr_reload |=> !pend_load_reg;
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("pending reload stuck");

  // core resolution moves only at an applied tick
  property p_res_hold;
    !(pend_res_reg && tick_32k) |=> $stable(core_res_reg);
  endproperty
  a_res_hold: assert property (p_res_hold) else $error("resolution moved off tick");

  // sleep request does not stop decrements
  property p_sleep_runs;
    sleep_en && count_tick && enabled && !core_load && (count != COUNT_RST)
      |=> count == $past(count) - COUNT_ONE;
  endproperty
  a_sleep_runs: assert property (p_sleep_runs) else $error("count stalled in sleep");

  // last decrement always raises the event
  property p_done_due;
    count_tick && enabled && !core_load && (count == COUNT_ONE) |=> wake_count_done_event;
  endproperty
  a_done_due: assert property (p_done_due) else $error("done event missed");

  // disabled counter never signals
  property p_quiet_off;
    !enabled |=> !wake_count_done_event;
  endproperty
  a_quiet_off: assert property (p_quiet_off) else $error("event while disabled");

  // scenario coverage
  c_expire:   cover property (wake_count_done_event);
  c_reload:   cover property (core_load && (reload_reg != COUNT_RST));
  c_disable:  cover property (core_load && (reload_reg == COUNT_RST) && enabled);
  c_coarse:   cover property (count_tick && core_res_reg && enabled);
  c_collide:  cover property (wr_reload && core_load);

endmodule

// >>> test/hwt_testbench.sv
// testbench: self-checking register and countdown tests for the wake timer
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; $display("[FAIL] %0t: got %h exp %h", $time, got, exp); end end

module testbench
  import hwt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [ADDR_W-1:0] a;
    logic              w;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] e;
  } hwt_row_s;

  logic              core_clk;
  logic              rst_n;
  logic              clk_32k_in;
  logic              sleep_en;
  hwt_req_s          reg_req;
  logic [DATA_W-1:0] reg_rdata;
  logic              clk_required;
  logic              wake_count_done_event;
  logic [DATA_W-1:0] rd;
  int                num_errors;
  int                n_compared;
  int                n_done;
  int                n_cycles;
  hwt_row_s          rows [9];

  hwt_wake_timer DUT (
    .core_clk              (core_clk),
    .rst_n                 (rst_n),
    .clk_32k_in            (clk_32k_in),
    .sleep_en              (sleep_en),
    .reg_req               (reg_req),
    .reg_rdata             (reg_rdata),
    .clk_required          (clk_required),
    .wake_count_done_event (wake_count_done_event)
  );

  // 100 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // done pulse counter and hang guard
  always @(posedge core_clk) begin
    n_cycles++;
    if (wake_count_done_event === 1'b1) n_done++;
    if (n_cycles == 60000) begin
      num_errors++;
      stop_test();
    end
  end

  // one-cycle write strobe
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
    #1;
  endtask

  // one-cycle read strobe, data one cycle later
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // one low-frequency period, compressed to four core cycles
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      clk_32k_in <= 1'b1;
      @(posedge core_clk);
      @(posedge core_clk);
      clk_32k_in <= 1'b0;
      @(posedge core_clk);
    end
    #1;
  endtask

  task automatic stop_test();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst_n      = 1'b0;
    clk_32k_in = 1'b0;
    sleep_en   = 1'b0;
    reg_req    = '0;
    num_errors = 0;
    n_compared = 0;
    n_done     = 0;
    n_cycles   = 0;
    // reset values, read-back, read-only and unmapped places
    rows = '{
      '{8'h00, 1'b0, 16'h0000, RELOAD_RST}, '{8'h04, 1'b0, 16'h0000, 16'h0000},
      '{8'h08, 1'b0, 16'h0000, COUNT_RST},  '{8'h0C, 1'b0, 16'h0000, 16'h0000},
      '{8'h00, 1'b1, 16'h1234, 16'h1234},   '{8'h04, 1'b1, 16'hFFFF, 16'h0001},
      '{8'h04, 1'b1, 16'h0000, 16'h0000},   '{8'h08, 1'b1, 16'h5555, 16'h0000},
      '{8'h0C, 1'b1, 16'hAAAA, 16'h0000}
    };
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    `CHK(clk_required, 1'b0)
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, rd);
      `CHK(rd, rows[i].e)
    end
    // pending reload keeps clock request up until a tick applies it
    `CHK(clk_required, 1'b1)
    tick(1);
    `CHK(clk_required, 1'b0)
    rd_reg(OFS_COUNT, rd);
    `CHK(rd, 16'h1234)
    // fine countdown from 3 with sleep requested throughout
    sleep_en <= 1'b1;
    wr_reg(OFS_RELOAD, 16'h0003);
    tick(1);
    n_done = 0;
    for (int k = 2; k >= 0; k--) begin
      tick(1);
      rd_reg(OFS_COUNT, rd);
      `CHK(rd, DATA_W'(k))
    end
    `CHK(n_done, 1)
    tick(3);
    rd_reg(OFS_COUNT, rd);
    `CHK(rd, 16'h0000)
    `CHK(n_done, 1)
    // zero reload stops a running count with no event
    wr_reg(OFS_RELOAD, 16'h0005);
    tick(2);
    rd_reg(OFS_COUNT, rd);
    `CHK(rd, 16'h0004)
    wr_reg(OFS_RELOAD, 16'h0000);
    tick(6);
    rd_reg(OFS_COUNT, rd);
    `CHK(rd, 16'h0000)
    `CHK(n_done, 1)
    // coarse resolution: one count per prescaled period
    wr_reg(OFS_CTRL, 16'h0001);
    wr_reg(OFS_RELOAD, COUNT_ONE);
    tick(1);
    tick(COARSE_TICKS - 1);
    rd_reg(OFS_COUNT, rd);
    `CHK(rd, COUNT_ONE)
    `CHK(n_done, 1)
    tick(1);
    rd_reg(OFS_COUNT, rd);
    `CHK(rd, 16'h0000)
    `CHK(n_done, 2)
    // reset in mid-count returns all to defaults
    wr_reg(OFS_RELOAD, 16'h0007);
    tick(1);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    `CHK(clk_required, 1'b0)
    rd_reg(OFS_COUNT, rd);
    `CHK(rd, COUNT_RST)
    rd_reg(OFS_RELOAD, rd);
    `CHK(rd, RELOAD_RST)
    rd_reg(OFS_CTRL, rd);
    `CHK(rd, 16'h0000)
    tick(3);
    `CHK(n_done, 2)
    stop_test();
  end

endmodule
